// *** hw/crccu_pkg.sv ***
// constants, register map and encodings of the crc calculation unit
package crccu_pkg;
	localparam logic [4:0]  OFS_DATA      = 5'h00;
	localparam logic [4:0]  OFS_SCRATCH   = 5'h04;
	localparam logic [4:0]  OFS_CTRL      = 5'h08;
	localparam logic [4:0]  OFS_INIT      = 5'h10;
	localparam logic [4:0]  OFS_POLY      = 5'h14;
	localparam logic [31:0] RST_DATA      = 32'hffffffff;
	localparam logic [31:0] RST_SCRATCH   = 32'h00000000;
	localparam logic [31:0] RST_INIT      = 32'hffffffff;
	localparam logic [31:0] RST_POLY      = 32'h04c11db7;
	localparam logic [7:0]  RST_CTRL      = 8'h00;
	localparam int          CTRL_RESET    = 0;
	localparam int          CTRL_SIZE_LO  = 3;
	localparam int          CTRL_SIZE_HI  = 4;
	localparam int          CTRL_RIN_LO   = 5;
	localparam int          CTRL_RIN_HI   = 6;
	localparam int          CTRL_ROUT     = 7;
	localparam logic [7:0]  CTRL_WMASK    = 8'hf8;
	localparam logic [1:0]  RIN_NONE      = 2'h0;
	localparam logic [1:0]  RIN_BYTE      = 2'h1;
	localparam logic [1:0]  RIN_HALF      = 2'h2;
	localparam logic [1:0]  RIN_WORD      = 2'h3;
	localparam logic [1:0]  PSZ_32        = 2'h0;
	localparam logic [1:0]  PSZ_16        = 2'h1;
	localparam logic [1:0]  PSZ_8         = 2'h2;
	localparam logic [1:0]  PSZ_7         = 2'h3;
	// ahb transfer size encodings and htrans
	localparam logic [2:0]  HSIZE_BYTE    = 3'h0;
	localparam logic [2:0]  HSIZE_HALF    = 3'h1;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
	localparam logic [2:0]  NBYTES_WORD   = 3'h4;
	localparam logic [2:0]  NBYTES_HALF   = 3'h2;
	localparam logic [2:0]  NBYTES_BYTE   = 3'h1;
	typedef enum logic [1:0] {
		CRCCU_IDLE = 2'b01,
		CRCCU_CALC = 2'b10
	} crccu_state_type;
endpackage : crccu_pkg

// *** hw/crccu_bitrev.sv ***
`timescale 1ns/1ps
// input bit reversal by byte, half-word or word, and output reversal
module crccu_bitrev (
	input  wire logic [31:0] din,
	input  wire logic [1:0]  mode,
	output logic      [31:0] dout
);
	logic [31:0] rev_word;
	logic [31:0] rev_half;
	logic [31:0] rev_byte;
	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_rev
			assign rev_word[i] = din[31 - i];
			assign rev_half[i] = din[(i / 16) * 16 + 15 - (i % 16)];
			assign rev_byte[i] = din[(i / 8) * 8 + 7 - (i % 8)];
		end
	endgenerate
	assign dout = (mode == crccu_pkg::RIN_WORD) ? rev_word :
	              (mode == crccu_pkg::RIN_HALF) ? rev_half :
	              (mode == crccu_pkg::RIN_BYTE) ? rev_byte : din;
endmodule : crccu_bitrev

// *** hw/crccu_byte_step.sv ***
`timescale 1ns/1ps
// one byte folded into the running crc, msb first, programmable width
module crccu_byte_step (
	input  wire logic [31:0] crc_in,
	input  wire logic [7:0]  data_byte,
	input  wire logic [31:0] poly,
	input  wire logic [1:0]  psize,
	output logic      [31:0] crc_out
);
	logic [5:0]  top;
	logic [31:0] mask;
	assign top  = (psize == crccu_pkg::PSZ_32) ? 6'd31 :
	              (psize == crccu_pkg::PSZ_16) ? 6'd15 :
	              (psize == crccu_pkg::PSZ_8)  ? 6'd7  : 6'd6;
	assign mask = (psize == crccu_pkg::PSZ_32) ? 32'hffffffff :
	              (psize == crccu_pkg::PSZ_16) ? 32'h0000ffff :
	              (psize == crccu_pkg::PSZ_8)  ? 32'h000000ff : 32'h0000007f;
	always_comb begin
		logic [31:0] c;
		logic        fb;
		c = crc_in & mask;
		fb = 1'b0;
		for (int b = 7; b >= 0; b--) begin
			fb = c[top[4:0]] ^ data_byte[b];
			c = ((c << 1) ^ (fb ? poly : 32'h0)) & mask;
		end
		crc_out = c;
	end
endmodule : crccu_byte_step

// *** hw/crccu_top.sv ***
`timescale 1ns/1ps
// crc calculation unit: ahb-lite slave, one-entry input buffer, byte-serial engine
// Behaviour
// RQ1 - polynomial register resets to 0x04c11db7
// RQ2 - polynomial fully programmable, width 7, 8, 16 or 32 bits
// RQ3 - software programs odd polynomials only
// RQ4 - one 32-bit data port: write feeds data, read gives result
// RQ5 - each data write folds into held crc, per byte or word
// RQ6 - data port takes 8, 16, 32-bit accesses; others 32-bit only
// RQ7 - update takes 4, 2 or 1 cycles for word, half, byte
// RQ8 - one pending input buffered so next write needs no wait
// RQ9 - write width may change between consecutive writes
// RQ10 - optional input reversal by byte, half-word or word
// RQ11 - optional bit-level reversal of the result read back
// RQ12 - reset control bit reloads crc with initial value, default ones
// RQ13 - writing initial value register also loads running crc
// RQ14 - scratch register unaffected by calculation reset
// RQ15 - narrow crc results read from low bits of data port
// RQ16 - software does not change polynomial mid-calculation
// RQ17 - narrow writes take value from low bits of data port
// RQ18 - data port resets to all ones, full 32-bit read/write
// RQ19 - input reversal codes: 00 none, 01 byte, 10 half, 11 word
// RQ20 - width codes: 00 32-bit, 01 16, 10 8, 11 7-bit
// RQ21 - reset control bit only settable, cleared by hardware
// RQ22 - narrow polynomials programmed in low register bits
// RQ23 - data read during pending calculation waits for the result
// RQ24 - input reversal applied per write using that write's width
module crccu_top (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [4:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	// address phase capture
	logic        ap_valid_reg;
	logic        ap_write_reg;
	logic [4:0]  ap_addr_reg;
	logic [2:0]  ap_size_reg;
	logic        ap_err_reg;
	logic        err2_reg;

	// registers
	logic [31:0] crc_reg;
	logic [31:0] scratch_reg;
	logic [31:0] init_reg;
	logic [31:0] polynomial_coeff_reg;
	logic [7:0]  calc_control_reg;

	// input buffer and engine
	logic        buf_valid_reg;
	logic [31:0] buf_data_reg;
	logic [2:0]  buf_nbytes_reg;
	logic [31:0] eng_data_reg;
	logic [2:0]  eng_left_reg;
	crccu_pkg::crccu_state_type state_reg;

	wire logic        trans_ok   = hsel & hready & (htrans == crccu_pkg::HTRANS_NONSEQ
	                                               | htrans == crccu_pkg::HTRANS_SEQ);
	wire logic        is_data_a  = (haddr == crccu_pkg::OFS_DATA);
	wire logic        size_ok_a  = (hsize == crccu_pkg::HSIZE_WORD) |
	                               (is_data_a & (hsize == crccu_pkg::HSIZE_HALF
	                                           | hsize == crccu_pkg::HSIZE_BYTE)); // [RQ6]
	wire logic        known_a    = is_data_a | haddr == crccu_pkg::OFS_SCRATCH
	                               | haddr == crccu_pkg::OFS_CTRL | haddr == crccu_pkg::OFS_INIT
	                               | haddr == crccu_pkg::OFS_POLY;
	wire logic        busy       = buf_valid_reg | (state_reg == crccu_pkg::CRCCU_CALC);
	wire logic        dp_live    = ap_valid_reg & ~ap_err_reg;
	wire logic        dp_data    = dp_live & (ap_addr_reg == crccu_pkg::OFS_DATA);
	// a second write lands in the buffer; only a third while both are full stalls
	wire logic        wr_stall   = dp_data & ap_write_reg & buf_valid_reg;       // [RQ8]
	wire logic        rd_stall   = dp_data & ~ap_write_reg & busy;               // [RQ23]
	wire logic        stall      = wr_stall | rd_stall;
	wire logic        dp_do      = dp_live & ~stall;
	wire logic        wr_data    = dp_do & ap_write_reg & dp_data;
	wire logic        wr_scratch = dp_do & ap_write_reg & (ap_addr_reg == crccu_pkg::OFS_SCRATCH);
	wire logic        wr_ctrl    = dp_do & ap_write_reg & (ap_addr_reg == crccu_pkg::OFS_CTRL);
	wire logic        wr_init    = dp_do & ap_write_reg & (ap_addr_reg == crccu_pkg::OFS_INIT);
	wire logic        wr_poly    = dp_do & ap_write_reg & (ap_addr_reg == crccu_pkg::OFS_POLY);
	wire logic        calc_rst   = wr_ctrl & hwdata[crccu_pkg::CTRL_RESET];
	wire logic [1:0]  psize      = calc_control_reg[crccu_pkg::CTRL_SIZE_HI:crccu_pkg::CTRL_SIZE_LO];
	wire logic [1:0]  rin        = calc_control_reg[crccu_pkg::CTRL_RIN_HI:crccu_pkg::CTRL_RIN_LO];
	wire logic        rout       = calc_control_reg[crccu_pkg::CTRL_ROUT];

	// narrow writes sit in the low lanes; byte writes never need half/word reversal
	wire logic [2:0]  wr_nbytes  = (ap_size_reg == crccu_pkg::HSIZE_BYTE) ? crccu_pkg::NBYTES_BYTE :
	                               (ap_size_reg == crccu_pkg::HSIZE_HALF) ? crccu_pkg::NBYTES_HALF :
	                               crccu_pkg::NBYTES_WORD;
	wire logic [31:0] wr_masked  = (wr_nbytes == crccu_pkg::NBYTES_BYTE) ? {24'h0, hwdata[7:0]} :
	                               (wr_nbytes == crccu_pkg::NBYTES_HALF) ? {16'h0, hwdata[15:0]} :
	                               hwdata;                                       // [RQ17]
	wire logic [1:0]  rin_eff    = (wr_nbytes == crccu_pkg::NBYTES_BYTE && rin != crccu_pkg::RIN_NONE)
	                               ? crccu_pkg::RIN_BYTE :
	                               (wr_nbytes == crccu_pkg::NBYTES_HALF && rin == crccu_pkg::RIN_WORD)
	                               ? crccu_pkg::RIN_HALF : rin;
	logic [31:0] wr_rev;
	crccu_bitrev u_rin (
		.din  (wr_masked),
		.mode (rin_eff),
		.dout (wr_rev)
	); // [RQ10] [RQ19] [RQ24]

	// engine: msb byte of the written width first, one byte per cycle
	wire logic [7:0]  cur_byte   = (eng_left_reg == crccu_pkg::NBYTES_WORD) ? eng_data_reg[31:24] :
	                               (eng_left_reg == 3'h3) ? eng_data_reg[23:16] :
	                               (eng_left_reg == crccu_pkg::NBYTES_HALF) ? eng_data_reg[15:8] :
	                               eng_data_reg[7:0];
	logic [31:0] crc_step;
	crccu_byte_step u_step (
		.crc_in    (crc_reg),
		.data_byte (cur_byte),
		.poly      (polynomial_coeff_reg),
		.psize     (psize),
		.crc_out   (crc_step)
	); // [RQ2] [RQ5] [RQ20]

	wire logic        eng_last   = (state_reg == crccu_pkg::CRCCU_CALC) &&
	                               (eng_left_reg == crccu_pkg::NBYTES_BYTE);
	wire logic        eng_free   = (state_reg == crccu_pkg::CRCCU_IDLE) | eng_last;
	wire logic        src_valid  = buf_valid_reg | wr_data;
	wire logic [31:0] src_data   = buf_valid_reg ? buf_data_reg : wr_rev;
	wire logic [2:0]  src_nbytes = buf_valid_reg ? buf_nbytes_reg : wr_nbytes;
	wire logic        load_eng   = eng_free & src_valid & ~calc_rst;
	wire logic        buf_load   = wr_data & (buf_valid_reg | ~eng_free);       // [RQ8]
	wire logic        buf_pop    = load_eng & buf_valid_reg;

	wire logic [31:0] crc_mask   = (psize == crccu_pkg::PSZ_32) ? 32'hffffffff :
	                               (psize == crccu_pkg::PSZ_16) ? 32'h0000ffff :
	                               (psize == crccu_pkg::PSZ_8)  ? 32'h000000ff : 32'h0000007f;
	logic [31:0] crc_rev;
	crccu_bitrev u_rout (
		.din  (crc_reg),
		.mode (crccu_pkg::RIN_WORD),
		.dout (crc_rev)
	);
	// a narrow result is reversed within its own width, then right-aligned
	wire logic [31:0] crc_out    = rout ? ((psize == crccu_pkg::PSZ_32) ? crc_rev :
	                                       (psize == crccu_pkg::PSZ_16) ? {16'h0, crc_rev[31:16]} :
	                                       (psize == crccu_pkg::PSZ_8)  ? {24'h0, crc_rev[31:24]} :
	                                       {25'h0, crc_rev[31:25]})
	                                    : (crc_reg & crc_mask);                  // [RQ11] [RQ15]
	wire logic [31:0] rd_mux     = (ap_addr_reg == crccu_pkg::OFS_DATA)    ? crc_out :
	                               (ap_addr_reg == crccu_pkg::OFS_SCRATCH) ? scratch_reg :
	                               (ap_addr_reg == crccu_pkg::OFS_CTRL)    ? {24'h0, calc_control_reg} :
	                               (ap_addr_reg == crccu_pkg::OFS_INIT)    ? init_reg :
	                               (ap_addr_reg == crccu_pkg::OFS_POLY)    ? polynomial_coeff_reg :
	                               32'h0;
	wire logic        rd_take    = dp_do & ~ap_write_reg;

	// the first error cycle holds the bus, as a two-cycle error response needs
	wire logic        err_first  = ap_err_reg & ~err2_reg;
	wire logic        ap_open    = ~stall & ~err_first;
	wire logic        flush      = calc_rst | wr_init;                         // [RQ12] [RQ13]
	wire logic        eng_step   = (state_reg == crccu_pkg::CRCCU_CALC) & ~eng_last & ~flush;
	wire logic        eng_take   = load_eng & ~flush;
	crccu_pkg::crccu_state_type state_next;

	assign hreadyout = ap_open;
	assign hresp     = ap_err_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg  <= crccu_pkg::OFS_DATA;
			ap_size_reg  <= crccu_pkg::HSIZE_WORD;
			ap_err_reg   <= 1'b0;
		end else if (ap_open) begin
			ap_valid_reg <= trans_ok;
			ap_write_reg <= hwrite;
			ap_addr_reg  <= haddr;
			ap_size_reg  <= hsize;
			ap_err_reg   <= trans_ok & ~(known_a & size_ok_a); // [RQ6]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			err2_reg <= 1'b0;
		end else begin
			err2_reg <= err_first;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h0;
		end else if (rd_take) begin
			hrdata <= rd_mux; // [RQ4]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scratch_reg <= crccu_pkg::RST_SCRATCH;
		end else if (wr_scratch) begin
			scratch_reg <= hwdata;                      // [RQ14]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_reg <= crccu_pkg::RST_INIT;
		end else if (wr_init) begin
			init_reg <= hwdata;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			polynomial_coeff_reg <= crccu_pkg::RST_POLY; // [RQ1]
		end else if (wr_poly) begin
			polynomial_coeff_reg <= hwdata;             // [RQ2]
		end
	end

	// reset bit is never stored, so it reads back as cleared
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			calc_control_reg <= crccu_pkg::RST_CTRL;
		end else if (wr_ctrl) begin
			calc_control_reg <= hwdata[7:0] & crccu_pkg::CTRL_WMASK; // [RQ21]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_valid_reg <= 1'b0;
		end else if (flush) begin
			buf_valid_reg <= 1'b0;
		end else if (buf_load) begin
			buf_valid_reg <= 1'b1;                      // [RQ8]
		end else if (buf_pop) begin
			buf_valid_reg <= 1'b0;
		end
	end

	// the buffered word keeps the width of its own write
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_data_reg   <= 32'h0;
			buf_nbytes_reg <= crccu_pkg::NBYTES_WORD;
		end else if (buf_load) begin
			buf_data_reg   <= wr_rev;
			buf_nbytes_reg <= wr_nbytes;                // [RQ9]
		end
	end

	// a reload wins over the engine, so stale bytes never reach the new crc
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			crc_reg <= crccu_pkg::RST_DATA;             // [RQ18]
		end else if (wr_init) begin
			crc_reg <= hwdata;                          // [RQ13]
		end else if (calc_rst) begin
			crc_reg <= init_reg;                        // [RQ12]
		end else if (state_reg == crccu_pkg::CRCCU_CALC) begin
			crc_reg <= crc_step;                        // [RQ7]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= crccu_pkg::CRCCU_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			crccu_pkg::CRCCU_IDLE: begin
				if (eng_take) begin
					state_next = crccu_pkg::CRCCU_CALC;
				end
			end
			crccu_pkg::CRCCU_CALC: begin
				if (eng_last & ~eng_take) begin
					state_next = crccu_pkg::CRCCU_IDLE;
				end
			end
			default: begin
				state_next = crccu_pkg::CRCCU_IDLE;
			end
		endcase
		if (flush) begin
			state_next = crccu_pkg::CRCCU_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			eng_data_reg <= 32'h0;
			eng_left_reg <= 3'h0;
		end else if (eng_take) begin
			eng_data_reg <= src_data;
			eng_left_reg <= src_nbytes;
		end else if (eng_step) begin
			eng_left_reg <= eng_left_reg - 3'h1;
		end
	end
endmodule : crccu_top

// *** dv/crccu_monitor.sv ***
// bus-port checker for the crc unit
`timescale 1ns/1ps
module crccu_monitor (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [4:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	logic       ap_ok;
	logic       ap_bad;
	logic       dp_act_reg;
	logic       dp_rd_reg;
	logic [3:0] quiet_reg;
	assign ap_ok = hsel && hready && htrans[1];
	assign ap_bad = haddr[1:0] != 2'h0 || haddr == 5'h0c || haddr > 5'h14
		|| hsize > 3'h2 || (haddr != 5'h00 && hsize != 3'h2);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dp_act_reg <= 1'b0;
			dp_rd_reg <= 1'b0;
			quiet_reg <= 4'hf;
		end else begin
			if (hready) begin
				dp_act_reg <= ap_ok;
				dp_rd_reg <= ap_ok && !hwrite;
			end
			// cycles since the last data write; engine surely idle after ten
			if (ap_ok && hwrite && haddr == 5'h00)
				quiet_reg <= 4'h0;
			else if (quiet_reg != 4'hf)
				quiet_reg <= quiet_reg + 4'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_err_first: assert property ($rose(hresp) |-> !hreadyout)
		else $error("error not started with wait");
	chk_err_second: assert property (hresp && !hreadyout |=> hresp && hreadyout)
		else $error("error second cycle wrong");
	chk_bad_refused: assert property (ap_ok && ap_bad |=> hresp && !hreadyout)
		else $error("bad access not refused");
	chk_good_taken: assert property (ap_ok && !ap_bad |=> !hresp)
		else $error("good access refused");
	chk_reg_nowait: assert property (ap_ok && !ap_bad && haddr != 5'h00 |=> hreadyout)
		else $error("register access waited");
	chk_idle_write: assert property (ap_ok && hwrite && haddr == 5'h00 && quiet_reg > 4'h9
		|=> hreadyout)
		else $error("idle data write waited");
	chk_read_bound: assert property (dp_rd_reg && !hreadyout |-> ##[1:9] hreadyout)
		else $error("read wait too long");
	chk_idle_ready: assert property (!dp_act_reg |-> hreadyout && !hresp)
		else $error("idle bus not ready");
	chk_rdata_hold: assert property (!(dp_rd_reg && hreadyout) |=> $stable(hrdata))
		else $error("read data moved");
endmodule : crccu_monitor
bind crccu_top crccu_monitor mon (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

// *** dv/crccu_ahb_master.sv ***
// bus master model: single non-pipelined transfers
`timescale 1ns/1ps
module crccu_ahb_master (
	input  wire logic        ref_clk,
	output logic             hsel,
	output logic [4:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp
);
	logic done_resp;
	event done_ev;
	initial begin
		hsel = 1'b0;
		haddr = 5'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		done_resp = 1'b0;
	end
	// entered just after a falling edge; released lines show inverted values
	task automatic xfer(input logic [4:0] a, input logic wr, input logic [2:0] sz,
			input logic [31:0] d, output int waits);
		waits = 0;
		hsel = 1'b1;
		haddr = a;
		htrans = crccu_pkg::HTRANS_NONSEQ;
		hwrite = wr;
		hsize = sz;
		@(negedge ref_clk);
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = ~a;
		hwrite = ~wr;
		hwdata = d;
		while (!hreadyout && waits < 20) begin
			waits++;
			@(negedge ref_clk);
		end
		done_resp = hresp;
		@(negedge ref_clk);
		hwdata = ~d;
		if (!wr || done_resp)
			-> done_ev;
	endtask : xfer
endmodule : crccu_ahb_master

// *** dv/test_crccu_top.sv ***
// self-checking bench for the crc unit
`timescale 1ns/1ps
module test_crccu_top;
	logic        ref_clk;
	logic        sys_rst;
	logic        hsel;
	logic [4:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          failures = 0;
	int          num_checks = 0;
	int          seed = 32'hb986;
	int          waits;
	int          w;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [31:0] crc_m;
	logic [31:0] poly;
	logic [31:0] d;
	logic [31:0] init_v;
	logic [1:0]  rin;
	logic        rout;
	crccu_top uut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp);
	crccu_ahb_master m (.ref_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hreadyout, .hresp);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = c[w - 1] ^ b[i];
			c = c << 1;
			if (fb)
				c = c ^ poly;
		end
		return c & (32'hffffffff >> (32 - w));
	endfunction : fold
	function automatic logic [31:0] rev(logic [31:0] v, int u, int n);
		logic [31:0] r;
		r = v;
		for (int k = 0; k < n; k += u)
			for (int i = 0; i < u; i++)
				r[k + i] = v[k + u - 1 - i];
		return r;
	endfunction : rev
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (exp !== got) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic rd(logic [4:0] a, logic [32:0] ex);
		exp_q.push_back(ex);
		m.xfer(a, 1'b0, crccu_pkg::HSIZE_WORD, 32'h0, waits);
		if (waits >= 20) chk("read wait limit", 32'h0, 32'(waits));
	endtask : rd
	task automatic wr(logic [4:0] a, logic [31:0] v);
		m.xfer(a, 1'b1, crccu_pkg::HSIZE_WORD, v, waits);
		if (waits >= 20) chk("write wait limit", 32'h0, 32'(waits));
	endtask : wr
	// data write of n bytes, also folded into the reference crc
	task automatic feed(int n, logic [31:0] v);
		logic [31:0] x;
		int u;
		u = (4 << rin) > 8 * n ? 8 * n : 4 << rin;
		x = rin == 2'h0 ? v : rev(v, u, 8 * n);
		for (int j = n - 1; j >= 0; j--)
			crc_m = fold(crc_m, x[8 * j +: 8]);
		m.xfer(crccu_pkg::OFS_DATA, 1'b1, 3'(n >> 1), v, waits);
		if (waits >= 20) chk("data write wait limit", 32'h0, 32'(waits));
	endtask : feed
	task automatic resets();
		rd(crccu_pkg::OFS_DATA, {1'b0, 32'hffffffff});
		rd(crccu_pkg::OFS_SCRATCH, 33'h0);
		rd(crccu_pkg::OFS_CTRL, 33'h0);
		rd(crccu_pkg::OFS_INIT, {1'b0, 32'hffffffff});
		rd(crccu_pkg::OFS_POLY, {1'b0, 32'h04c11db7});
	endtask : resets
	task automatic summarize();
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	always @(m.done_ev) begin
		if (exp_q.size() == 0) begin
			chk("unexpected response", 32'h0, 32'h1);
		end else begin
			e = exp_q.pop_front();
			if (e[32])
				chk("hresp", 32'h1, {31'h0, m.done_resp});
			else
				chk("hrdata", e[31:0], hrdata);
		end
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		summarize();
	end
	initial begin
		sys_rst = 1'b1;
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		resets();
		rd(5'h0c, {1'b1, 32'h0});
		d = $random(seed);
		wr(crccu_pkg::OFS_SCRATCH, d);
		exp_q.push_back({1'b1, 32'h0});
		m.xfer(crccu_pkg::OFS_SCRATCH, 1'b1, crccu_pkg::HSIZE_HALF, ~d, waits);
		rd(crccu_pkg::OFS_SCRATCH, {1'b0, d});
		for (int k = 0; k < 16; k++) begin
			rin = 2'(k);
			w = k < 4 ? 32 : k < 8 ? 16 : k < 12 ? 8 : 7;
			rout = k[0] ^ k[2];
			poly = $random(seed) & (32'hffffffff >> (32 - w)) | 32'h1;
			wr(crccu_pkg::OFS_CTRL, {24'h0, rout, rin, 2'(k >> 2), 3'h0});
			rd(crccu_pkg::OFS_CTRL, {25'h0, rout, rin, 2'(k >> 2), 3'h0});
			wr(crccu_pkg::OFS_POLY, poly);
			rd(crccu_pkg::OFS_POLY, {1'b0, poly});
			crc_m = $random(seed) & (32'hffffffff >> (32 - w));
			wr(crccu_pkg::OFS_INIT, crc_m);
			feed(4, $random(seed));
			feed(4, $random(seed));
			chk("second write waits", 32'h0, 32'(waits));
			feed(2, $random(seed));
			feed(1, $random(seed));
			rd(crccu_pkg::OFS_DATA, {1'b0, rout ? rev(crc_m, w, w) : crc_m});
		end
		w = 32;
		rin = 2'h0;
		wr(crccu_pkg::OFS_CTRL, 32'h0);
		crc_m = $random(seed);
		wr(crccu_pkg::OFS_INIT, crc_m);
		init_v = crc_m;
		feed(4, $random(seed));
		wr(crccu_pkg::OFS_CTRL, 32'h1);
		rd(crccu_pkg::OFS_DATA, {1'b0, init_v});
		rd(crccu_pkg::OFS_CTRL, 33'h0);
		rd(crccu_pkg::OFS_SCRATCH, {1'b0, d});
		sys_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		resets();
		@(negedge ref_clk);
		summarize();
	end
endmodule : test_crccu_top
